/* File: dscg_gate.sv */
// apb slave holding run, sleep and deep-sleep unit gating plus access fault check
// assumes cpu power state levels come from logic on pclk; unit enables feed clock gate cells
`timescale 1ns/1ps
`default_nettype none

module dscg_gate #(
	parameter int NU = dscg_pkg::NUM_UNITS
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   paddr,
	input  wire logic [31:0]   pwdata,
	output var  logic          pready,
	output var  logic [31:0]   prdata,
	output var  logic          pslverr,
	// processor power state
	input  wire logic          cpu_sleep,
	input  wire logic          cpu_deep,
	// peripheral access check
	input  wire logic          periph_req,
	input  wire logic [2:0]    periph_unit,
	output var  logic          periph_done,
	output var  logic          periph_fault,
	// unit clock enables and interrupt
	output var  logic [NU-1:0] unit_clk_en,
	output var  logic          irq
);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [NU-1:0] units_of(input logic [31:0] r);
		units_of = {r[dscg_pkg::COMPARATOR_B_POS], r[dscg_pkg::COMPARATOR_A_POS],
			r[dscg_pkg::GP_TIMER_D_POS], r[dscg_pkg::GP_TIMER_C_POS],
			r[dscg_pkg::GP_TIMER_B_POS], r[dscg_pkg::GP_TIMER_A_POS]};
	endfunction : units_of

	function automatic logic hit(input logic [31:0] a, input logic [11:0] off);
		hit = (a == dscg_pkg::BASE_ADDR + {20'h0_0000, off});
	endfunction : hit

	////////////////////////////////////////////////////////////////////////
	// apb handshake: one wait state, answer in the second access cycle

	dscg_pkg::dscg_apb_req_t req;
	logic                    pready_q;
	logic [31:0]             prdata_q;
	logic                    pslverr_q;
	logic                    wr_done;
	logic                    mapped;

	assign req.addr  = paddr;
	assign req.write = pwrite;
	assign req.wdata = pwdata;

	assign mapped = hit(req.addr, dscg_pkg::RCC_OFF) || hit(req.addr, dscg_pkg::RUN_GATE_OFF)
		|| hit(req.addr, dscg_pkg::SLP_GATE_OFF) || hit(req.addr, dscg_pkg::DSL_GATE_OFF)
		|| hit(req.addr, dscg_pkg::IRQ_STAT_OFF) || hit(req.addr, dscg_pkg::IRQ_EN_OFF)
		|| hit(req.addr, dscg_pkg::IRQ_CLR_OFF);

	// write takes effect only at the edge that samples pready high
	assign wr_done = psel && penable && pready_q && req.write && mapped;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= psel && penable && !pready_q;
			pslverr_q <= psel && penable && !pready_q && !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// rcc auto gating register, then gating registers, one per power state

	logic [31:0] rcc_q;
	logic [31:0] run_q;
	logic [31:0] slp_q;
	logic [31:0] dsl_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcc_q <= dscg_pkg::RCC_RESET;
			run_q <= dscg_pkg::GATE_RESET;
			slp_q <= dscg_pkg::GATE_RESET;
			dsl_q <= dscg_pkg::GATE_RESET;
		end else if (wr_done) begin
			// reserved positions never store, so they gate nothing
			if (hit(req.addr, dscg_pkg::RCC_OFF))
				rcc_q <= req.wdata & dscg_pkg::RCC_MASK;
			if (hit(req.addr, dscg_pkg::RUN_GATE_OFF))
				run_q <= req.wdata & dscg_pkg::GATE_MASK;
			if (hit(req.addr, dscg_pkg::SLP_GATE_OFF))
				slp_q <= req.wdata & dscg_pkg::GATE_MASK;
			if (hit(req.addr, dscg_pkg::DSL_GATE_OFF))
				dsl_q <= req.wdata & dscg_pkg::GATE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power state tracking

	dscg_pkg::dscg_mode_t mode_q;
	dscg_pkg::dscg_mode_t mode_d;
	logic                 auto_gate;

	assign auto_gate = rcc_q[dscg_pkg::AUTO_GATING_POS];

	always_comb begin
		if (cpu_deep)
			mode_d = dscg_pkg::DSCG_DEEP;
		else if (cpu_sleep)
			mode_d = dscg_pkg::DSCG_SLEEP;
		else
			mode_d = dscg_pkg::DSCG_RUN;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_q <= dscg_pkg::DSCG_RUN;
		else
			mode_q <= mode_d;
	end

	////////////////////////////////////////////////////////////////////////
	// unit clock enables

	logic [NU-1:0] en_q;
	logic [NU-1:0] en_d;

	always_comb begin
		case (mode_q)
			dscg_pkg::DSCG_SLEEP:
				en_d = auto_gate ? units_of(slp_q) : units_of(run_q);
			dscg_pkg::DSCG_DEEP:
				en_d = auto_gate ? units_of(dsl_q) : units_of(run_q);
			default:
				en_d = units_of(run_q);
		endcase
	end

	// one flop per unit keeps the enable glitch free at the gate cell
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_q <= '0;
		else
			en_q <= en_d;
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral access check: an unclocked or missing unit faults

	logic done_q;
	logic fault_q;
	logic unit_live;

	assign unit_live = (periph_unit < 3'(NU)) && en_q[periph_unit];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_q  <= 1'b0;
			fault_q <= 1'b0;
		end else begin
			done_q  <= periph_req && unit_live;
			fault_q <= periph_req && !unit_live;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: sticky status, enable, write-one-to-clear

	logic [dscg_pkg::NUM_IRQ-1:0] stat_q;
	logic [dscg_pkg::NUM_IRQ-1:0] irq_en_q;
	logic [dscg_pkg::NUM_IRQ-1:0] ev;
	logic [dscg_pkg::NUM_IRQ-1:0] clr;
	logic                         irq_q;

	assign ev[dscg_pkg::IRQ_FAULT_POS] = periph_req && !unit_live;
	assign ev[dscg_pkg::IRQ_ENTER_POS] = mode_d == dscg_pkg::DSCG_DEEP
		&& mode_q != dscg_pkg::DSCG_DEEP;
	assign ev[dscg_pkg::IRQ_WAKE_POS]  = mode_d != dscg_pkg::DSCG_DEEP
		&& mode_q == dscg_pkg::DSCG_DEEP;
	assign clr = (wr_done && hit(req.addr, dscg_pkg::IRQ_CLR_OFF)) ?
		req.wdata[dscg_pkg::NUM_IRQ-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_q <= dscg_pkg::IRQ_RESET;
		else
			stat_q <= (stat_q & ~clr) | ev; // set wins over clear
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_en_q <= dscg_pkg::IRQ_RESET;
		else if (wr_done && hit(req.addr, dscg_pkg::IRQ_EN_OFF))
			irq_en_q <= req.wdata[dscg_pkg::NUM_IRQ-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(((stat_q & ~clr) | ev) & irq_en_q);
	end

	////////////////////////////////////////////////////////////////////////
	// read data, latched in the wait cycle

	logic [31:0] rd_d;

	always_comb begin
		rd_d = '0;
		if (hit(req.addr, dscg_pkg::RCC_OFF))
			rd_d = rcc_q;
		if (hit(req.addr, dscg_pkg::RUN_GATE_OFF))
			rd_d = run_q;
		if (hit(req.addr, dscg_pkg::SLP_GATE_OFF))
			rd_d = slp_q;
		if (hit(req.addr, dscg_pkg::DSL_GATE_OFF))
			rd_d = dsl_q;
		if (hit(req.addr, dscg_pkg::IRQ_STAT_OFF))
			rd_d = {29'h0, stat_q};
		if (hit(req.addr, dscg_pkg::IRQ_EN_OFF))
			rd_d = {29'h0, irq_en_q};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata_q <= '0;
		else if (psel && penable && !pready_q && !req.write)
			prdata_q <= rd_d;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign pready       = pready_q;
	assign prdata       = prdata_q;
	assign pslverr      = pslverr_q;
	assign periph_done  = done_q;
	assign periph_fault = fault_q;
	assign unit_clk_en  = en_q;
	assign irq          = irq_q;

	////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_leave_deep;
		mode_q == dscg_pkg::DSCG_DEEP ##1 mode_q == dscg_pkg::DSCG_RUN;
	endsequence

	sequence s_wait_answer;
		psel && penable && !pready_q ##1 pready_q;
	endsequence

	chk_deep_applies: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == dscg_pkg::DSCG_DEEP && auto_gate) |=> en_q == units_of($past(dsl_q)))
		else $error("deep-sleep gating not applied");

	chk_auto_gate_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		!auto_gate |=> en_q == units_of($past(run_q)))
		else $error("low-power gating used without auto gating");

	chk_wake_restore: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_leave_deep |=> en_q == units_of($past(run_q)))
		else $error("run gating not restored on wake");

	chk_unclocked_fault: assert property (
		@(posedge pclk) disable iff (!presetn)
		(periph_req && !unit_live) |=> (fault_q && !done_q))
		else $error("access to unclocked unit did not fault");

	chk_clocked_ok: assert property (
		@(posedge pclk) disable iff (!presetn)
		(periph_req && unit_live) |=> (done_q && !fault_q))
		else $error("access to clocked unit faulted");

	chk_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		((dsl_q | run_q | slp_q) & ~dscg_pkg::GATE_MASK) == 32'h0000_0000)
		else $error("reserved gating bit stored");

	chk_reset_clear: assert property (
		@(posedge pclk)
		$rose(presetn) |-> (dsl_q == 32'h0000_0000 && run_q == 32'h0000_0000 && en_q == '0))
		else $error("gating not clear after reset");

	chk_deep_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_done && paddr == 32'h400f_e124) |=> dsl_q == ($past(pwdata) & dscg_pkg::GATE_MASK))
		else $error("deep-sleep gating write lost");

	chk_one_unit: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == dscg_pkg::DSCG_RUN && $stable(run_q))
			|=> en_q[4] == $past(run_q[dscg_pkg::COMPARATOR_A_POS]))
		else $error("comparator enable not tied to its bit");

	chk_apb_answer: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_wait_answer |=> !pready_q)
		else $error("apb answer longer than one cycle");

	chk_sleep_applies: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == dscg_pkg::DSCG_SLEEP && auto_gate) |=> en_q == units_of($past(slp_q)))
		else $error("sleep gating not applied");

	chk_run_applies: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_q == dscg_pkg::DSCG_RUN) |=> en_q == units_of($past(run_q)))
		else $error("run gating not applied in run mode");

	chk_fault_status: assert property (
		@(posedge pclk) disable iff (!presetn)
		(periph_req && !unit_live) |=> stat_q[dscg_pkg::IRQ_FAULT_POS])
		else $error("access fault not recorded in status");

	chk_wake_status: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_leave_deep |-> stat_q[dscg_pkg::IRQ_WAKE_POS])
		else $error("wake from deep sleep not recorded");

	chk_irq_level: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_q == |(stat_q & $past(irq_en_q)))
		else $error("irq level does not follow enabled status");

	chk_unmapped_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready_q && !mapped) |=> (pready_q && pslverr_q))
		else $error("unmapped access not refused");

	chk_deep_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready_q && !pwrite && paddr == 32'h400f_e124) |=> prdata_q == $past(dsl_q))
		else $error("deep-sleep gating read wrong");

endmodule : dscg_gate

`default_nettype wire

/* File: dscg_pkg.sv */
// constants, field layouts and carrier types for the deep-sleep clock gating block
// assumes a single 100 MHz clock domain and an apb master in front of it
package dscg_pkg;

	localparam logic [31:0] BASE_ADDR    = 32'h400f_e000;
	localparam logic [11:0] RCC_OFF      = 12'h060;
	localparam logic [11:0] RUN_GATE_OFF = 12'h104;
	localparam logic [11:0] SLP_GATE_OFF = 12'h114;
	localparam logic [11:0] DSL_GATE_OFF = 12'h124;
	localparam logic [11:0] IRQ_STAT_OFF = 12'h200;
	localparam logic [11:0] IRQ_EN_OFF   = 12'h204;
	localparam logic [11:0] IRQ_CLR_OFF  = 12'h208;

	// unit field positions inside every gating register, then the auto gating bit of rcc and the unit count
	localparam int GP_TIMER_A_POS   = 16;
	localparam int GP_TIMER_B_POS   = 17;
	localparam int GP_TIMER_C_POS   = 18;
	localparam int GP_TIMER_D_POS   = 19;
	localparam int COMPARATOR_A_POS = 24;
	localparam int COMPARATOR_B_POS = 25;
	localparam int AUTO_GATING_POS  = 27;
	localparam int NUM_UNITS        = 6;

	localparam logic [31:0] GATE_MASK   = 32'h030f_0000;
	localparam logic [31:0] RCC_MASK    = 32'h0800_0000;
	localparam logic [31:0] GATE_RESET  = 32'h0000_0000;
	localparam logic [31:0] RCC_RESET   = 32'h0000_0000;

	// interrupt status bit positions
	localparam int IRQ_FAULT_POS = 0;
	localparam int IRQ_ENTER_POS = 1;
	localparam int IRQ_WAKE_POS  = 2;
	localparam int NUM_IRQ       = 3;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	typedef enum logic [1:0] {
		DSCG_RUN   = 2'b00,
		DSCG_SLEEP = 2'b01,
		DSCG_DEEP  = 2'b10
	} dscg_mode_t;

	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [31:0] wdata;
	} dscg_apb_req_t;

endpackage : dscg_pkg

/* File: test_deep_sleep_clock_gating.sv */
// self-checking bench for the deep-sleep clock gating block: apb registers, power modes, access faults, irq
// assumes dscg_pkg and dscg_gate are compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none

module test_deep_sleep_clock_gating;

	logic                            pclk;
	logic                            presetn;
	logic                            psel;
	logic                            penable;
	logic                            pwrite;
	logic [31:0]                     paddr;
	logic [31:0]                     pwdata;
	logic                            pready;
	logic [31:0]                     prdata;
	logic                            pslverr;
	logic                            cpu_sleep;
	logic                            cpu_deep;
	logic                            periph_req;
	logic [2:0]                      periph_unit;
	logic                            periph_done;
	logic                            periph_fault;
	logic [dscg_pkg::NUM_UNITS-1:0]  unit_clk_en;
	logic                            irq;
	int                              fail_count;
	int                              num_checks;
	int                              cycles;
	logic [31:0]                     rd;
	logic                            err;
	logic [31:0]                     g_run;
	logic [31:0]                     g_slp;
	logic [31:0]                     g_dsl;
	logic                            auto_sel;

	dscg_gate dut_u (
		.pclk         (pclk),
		.presetn      (presetn),
		.psel         (psel),
		.penable      (penable),
		.pwrite       (pwrite),
		.paddr        (paddr),
		.pwdata       (pwdata),
		.pready       (pready),
		.prdata       (prdata),
		.pslverr      (pslverr),
		.cpu_sleep    (cpu_sleep),
		.cpu_deep     (cpu_deep),
		.periph_req   (periph_req),
		.periph_unit  (periph_unit),
		.periph_done  (periph_done),
		.periph_fault (periph_fault),
		.unit_clk_en  (unit_clk_en),
		.irq          (irq)
	);

	////////////////////////////////////////////////////////////////////////////
	initial pclk = 1'b0;
	always #5 pclk = ~pclk;

	// whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			stop_test();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// reads sample pready before this edge's updates land, as a real master does
	task automatic apb(input logic wr, input logic [11:0] off, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= dscg_pkg::BASE_ADDR + {20'h0, off};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic logic [5:0] en_of(input logic [31:0] g);
		return {g[dscg_pkg::COMPARATOR_B_POS], g[dscg_pkg::COMPARATOR_A_POS], g[19:16]};
	endfunction : en_of

	function automatic logic [5:0] expect_en();
		if (cpu_deep && auto_sel) return en_of(g_dsl);
		if (cpu_sleep && auto_sel) return en_of(g_slp);
		return en_of(g_run);
	endfunction : expect_en

	task automatic load_gates(input logic [31:0] r, input logic [31:0] s, input logic [31:0] d, input logic a);
		apb(1'b1, dscg_pkg::RUN_GATE_OFF, r);
		apb(1'b1, dscg_pkg::SLP_GATE_OFF, s);
		apb(1'b1, dscg_pkg::DSL_GATE_OFF, d);
		apb(1'b1, dscg_pkg::RCC_OFF, {4'h0, a, 27'h0});
		apb(1'b0, dscg_pkg::DSL_GATE_OFF, 32'h0);
		check(rd, d & 32'h030f_0000);
		g_run = r;
		g_slp = s;
		g_dsl = d;
		auto_sel = a;
	endtask : load_gates

	// mode flop then enable flop: settled by the third edge
	task automatic set_mode(input logic s, input logic d);
		@(posedge pclk);
		cpu_sleep <= s;
		cpu_deep  <= d;
		repeat (3) @(posedge pclk);
		check({26'h0, unit_clk_en}, {26'h0, expect_en()});
	endtask : set_mode

	task automatic access_all();
		logic [5:0] e;
		logic       f;
		e = expect_en();
		for (int u = 0; u < 8; u++) begin
			f = (u > 5) ? 1'b1 : ~e[u];
			@(posedge pclk);
			periph_req  <= 1'b1;
			periph_unit <= u[2:0];
			@(posedge pclk);
			periph_req <= 1'b0;
			@(posedge pclk);
			check({30'h0, periph_fault, periph_done}, {30'h0, f, ~f});
		end
	endtask : access_all

	////////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		cpu_sleep = 1'b0;
		cpu_deep = 1'b0;
		periph_req = 1'b0;
		periph_unit = 3'h0;
		fail_count = 0;
		num_checks = 0;
		cycles = 0;
		g_run = 32'h0;
		g_slp = 32'h0;
		g_dsl = 32'h0;
		auto_sel = 1'b0;
		void'($urandom(33));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({26'h0, unit_clk_en}, 32'h0);
		apb(1'b0, dscg_pkg::DSL_GATE_OFF, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, dscg_pkg::RUN_GATE_OFF, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, dscg_pkg::SLP_GATE_OFF, 32'h0);
		check(rd, 32'h0);
		access_all();
		// unmapped place refuses with an error
		apb(1'b1, 12'h300, 32'hffff_ffff);
		check({31'h0, err}, 32'h1);
		apb(1'b0, 12'h300, 32'h0);
		check({31'h0, err}, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, dscg_pkg::IRQ_EN_OFF, 32'h1);
		load_gates(32'hffff_ffff, 32'h0, 32'h0300_0000, 1'b1);
		for (int i = 0; i < 6; i++) begin
			if (i > 0) begin
				load_gates($urandom(), $urandom(), $urandom(), i[0]);
			end
			set_mode(1'b0, 1'b0);
			access_all();
			set_mode(1'b1, 1'b0);
			access_all();
			set_mode(1'b0, 1'b1);
			access_all();
		end
		// read-modify-write: reserved bits written back as read
		apb(1'b0, dscg_pkg::DSL_GATE_OFF, 32'h0);
		apb(1'b1, dscg_pkg::DSL_GATE_OFF, rd | 32'h0001_0000);
		apb(1'b0, dscg_pkg::DSL_GATE_OFF, 32'h0);
		check(rd, (g_dsl & 32'h030f_0000) | 32'h0001_0000);
		// fault raised, then masked, cleared and a wake event seen
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h1);
		apb(1'b0, dscg_pkg::IRQ_STAT_OFF, 32'h0);
		check(rd & 32'h1, 32'h1);
		apb(1'b1, dscg_pkg::IRQ_EN_OFF, 32'h0);
		repeat (2) @(posedge pclk);
		check({31'h0, irq}, 32'h0);
		apb(1'b1, dscg_pkg::IRQ_CLR_OFF, 32'h7);
		apb(1'b0, dscg_pkg::IRQ_STAT_OFF, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, dscg_pkg::IRQ_EN_OFF, 32'h7);
		set_mode(1'b0, 1'b0);
		apb(1'b0, dscg_pkg::IRQ_STAT_OFF, 32'h0);
		check(rd, 32'h4);
		check({31'h0, irq}, 32'h1);
		stop_test();
	end

endmodule : test_deep_sleep_clock_gating

`default_nettype wire
